/* File: shared/fsw_regs.vh */
`ifndef FSW_REGS_VH
`define FSW_REGS_VH
// Status register field positions
`define FSW_SRWD_BIT      7
`define FSW_BP3_BIT       6
`define FSW_TB_BIT        5
`define FSW_BP2_BIT       4
`define FSW_BP1_BIT       3
`define FSW_BP0_BIT       2
`define FSW_WEL_BIT       1
`define FSW_WIP_BIT       0
// Nonvolatile bits that a status write may change
`define FSW_NV_MASK       8'hFC
`define FSW_SR_RESET      8'h00
// Command opcodes
`define FSW_CMD_WREN      8'h06
`define FSW_CMD_WRDI      8'h04
`define FSW_CMD_RDSR      8'h05
`define FSW_CMD_WRSR      8'h01
`define FSW_CMD_PP        8'h02
`define FSW_CMD_SE        8'hD8
`define FSW_CMD_BE        8'hC7
// Array geometry
`define FSW_ADDR_W        25
`define FSW_LAST_ADDR     25'h1FFFFFF
`define FSW_SECT_W        9
`define FSW_SECT_LAST     9'h1FF
// Busy time in link-clock-free mclk cycles
`define FSW_BUSY_NS       2000
`define FSW_CLK_NS        100
`define FSW_BUSY_CYC      ((`FSW_BUSY_NS + `FSW_CLK_NS - 1) / `FSW_CLK_NS)
`endif

/* File: design/fsw_sync.v */
module fsw_sync #(
  parameter W = 1
) (
  input  wire         mclk_i,   // System clock
  input  wire         rst_i,    // Sync reset
  input  wire [W-1:0] d_i,      // Async inputs
  output wire [W-1:0] q_o       // Synchronised
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end
  assign q_o = s2_r;
endmodule // fsw_sync

/* File: design/fsw_prot.v */
`include "fsw_regs.vh"
module fsw_prot (
  input  wire [3:0]              bp_i,     // Block-protect code
  input  wire                    tb_i,     // Top/bottom select
  input  wire [`FSW_SECT_W-1:0]  sect_i,   // Target sector
  output reg                     hit_o     // Sector protected
);
  reg [`FSW_SECT_W:0] n;
  reg [`FSW_SECT_W:0] s;
  always @* begin
    if (bp_i == 4'h0)
      n = 10'h000;
    else if (bp_i >= 4'hA)
      n = 10'h200;
    else
      n = 10'h001 << (bp_i - 4'h1);
    s = {1'b0, sect_i};
    if (tb_i)
      hit_o = (s < n);
    else
      hit_o = (s >= (10'h200 - n));
  end
endmodule // fsw_prot

/* File: design/fsw_status.v */
// Function
// - Read-status returns the register and write-status loads it.
// - Bit 7 set with protect pin low makes status writes ignored.
// - Hardware protection ends when the protect pin goes high or sys_rst_i clears bit 7.
// - Bit 7 is nonvolatile, default 0, disabling writes with pin low.
// - Bit 5 selects top (0, default) or bottom (1) protected region.
// - Bits 6 and 4:2 are block-protect bits guarding program and erase.
// - Bulk erase runs only when every block-protect bit is 0.
// - The write-enable latch is 0 at power-up and gates any modify.
// - Bit 0 reads 1 while a write, program or erase cycle runs.
// - Bit 0 is always the inverse of the ready flag.
// - The array covers 0 to 01FF FFFFh in 512 sectors of 64KB; the 3-byte address here reaches sectors 0 to 255 only.
`include "fsw_regs.vh"
module fsw_status #(
  parameter BUSY_CYC = `FSW_BUSY_CYC
) (
  input  wire  mclk_i,         // 10 MHz system clock
  input  wire  sys_rst_i,      // Sync reset, active high
  input  wire  spi_clk_i,      // Serial clock pin
  input  wire  spi_cs_n_i,     // Chip select pin, active low
  input  wire  spi_mosi_i,     // Serial data in
  input  wire  wp_n_i,         // Write-protect pin, active low
  output reg   spi_miso_o,     // Serial data out
  output reg   spi_miso_oe_n_o,// Low while driving data out
  output reg   ready_o,        // Ready flag (inverse of busy)
  output reg   prot_err_o,     // Rejected by protection, level
  output reg   array_go_o,     // Pulse: accepted program/erase
  output reg   [7:0] status_o  // Status register copy
);
  localparam ST_CMD  = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_RD   = 3'h3;
  localparam ST_IGN  = 3'h4;

  wire [3:0] in_s;
  wire       sclk_s;
  wire       cs_n_s;
  wire       mosi_s;
  wire       wp_n_s;
  fsw_sync #(.W(4)) u_sync (
    .mclk_i (mclk_i),
    .rst_i  (sys_rst_i),
    // Select inverted so the reset value reads as deselected
    .d_i    ({spi_clk_i, ~spi_cs_n_i, spi_mosi_i, wp_n_i}),
    .q_o    (in_s)
  );
  assign sclk_s = in_s[3];
  assign cs_n_s = ~in_s[2];
  assign mosi_s = in_s[1];
  assign wp_n_s = in_s[0];

  reg        sclk_d_r;
  reg        cs_d_r;
  wire       rise = sclk_s & ~sclk_d_r & ~cs_n_s;
  wire       fall = ~sclk_s & sclk_d_r & ~cs_n_s;
  wire       cs_end = cs_n_s & ~cs_d_r;

  reg  [2:0]  st_r;
  reg  [7:0]  shf_r;
  reg  [4:0]  cnt_r;
  reg  [7:0]  cmd_r;
  reg  [23:0] addr_r;
  reg  [7:0]  wdat_r;
  reg  [7:0]  sr_r;
  reg  [7:0]  rd_r;
  reg         busy_r;
  reg  [15:0] bcnt_r;
  reg         got_data_r;
  reg         addr_ok_r;

  wire [3:0] bp = {sr_r[`FSW_BP3_BIT], sr_r[`FSW_BP2_BIT],
                   sr_r[`FSW_BP1_BIT], sr_r[`FSW_BP0_BIT]};
  wire       wel = sr_r[`FSW_WEL_BIT];
  wire       hw_lock = sr_r[`FSW_SRWD_BIT] & ~wp_n_s;
  wire [7:0] shf_nxt = {shf_r[6:0], mosi_s};
  wire       hit;
  fsw_prot u_prot (
    .bp_i   (bp),
    .tb_i   (sr_r[`FSW_TB_BIT]),
    // 3-byte address: sector top bit always 0
    .sect_i ({1'b0, addr_r[23:16]}),
    .hit_o  (hit)
  );

  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sclk_d_r        <= 1'b0;
      cs_d_r          <= 1'b1;
      st_r            <= ST_CMD;
      shf_r           <= 8'h00;
      cnt_r           <= 5'h00;
      cmd_r           <= 8'h00;
      addr_r          <= 24'h000000;
      wdat_r          <= 8'h00;
      sr_r            <= `FSW_SR_RESET;
      rd_r            <= 8'h00;
      busy_r          <= 1'b0;
      bcnt_r          <= 16'h0000;
      got_data_r      <= 1'b0;
      addr_ok_r       <= 1'b0;
      spi_miso_o      <= 1'b0;
      spi_miso_oe_n_o <= 1'b1;
      ready_o         <= 1'b1;
      prot_err_o      <= 1'b0;
      array_go_o      <= 1'b0;
      status_o        <= `FSW_SR_RESET;
    end else begin
      sclk_d_r   <= sclk_s;
      cs_d_r     <= cs_n_s;
      array_go_o <= 1'b0;
      if (busy_r) begin
        if (bcnt_r == 16'h0000) begin
          busy_r <= 1'b0;
          sr_r[`FSW_WEL_BIT] <= 1'b0;
        end else begin
          bcnt_r <= bcnt_r - 16'h0001;
        end
      end
      if (rise) begin
        cnt_r <= cnt_r + 5'h01;
        shf_r <= shf_nxt;
        case (st_r)
          ST_CMD: if (cnt_r == 5'h07) begin
            cmd_r <= shf_nxt;
            cnt_r <= 5'h00;
            got_data_r <= 1'b0;
            addr_ok_r  <= 1'b0;
            // Busy device only answers status reads
            if (shf_nxt == `FSW_CMD_RDSR)
              st_r <= ST_RD;
            else if (busy_r)
              st_r <= ST_IGN;
            else if (shf_nxt == `FSW_CMD_WRSR)
              st_r <= ST_DATA;
            else if (shf_nxt == `FSW_CMD_PP || shf_nxt == `FSW_CMD_SE)
              st_r <= ST_ADDR;
            else
              st_r <= ST_IGN;
          end
          ST_ADDR: if (cnt_r == 5'h17) begin
            addr_r    <= {addr_r[22:0], mosi_s};
            addr_ok_r <= 1'b1;
            cnt_r     <= 5'h00;
            st_r      <= ST_IGN;
          end else begin
            addr_r <= {addr_r[22:0], mosi_s};
          end
          ST_DATA: if (cnt_r == 5'h07) begin
            wdat_r     <= shf_nxt;
            got_data_r <= 1'b1;
            st_r       <= ST_IGN;
          end
          default: ;
        endcase
      end
      // Read status out on falling edge
      if (st_r == ST_RD) begin
        spi_miso_oe_n_o <= 1'b0;
        if (fall) begin
          spi_miso_o <= rd_r[7];
          rd_r       <= {rd_r[6:0], rd_r[7]};
        end
      end
      if (st_r == ST_CMD)
        rd_r <= {sr_r[7:1], busy_r};
      if (cs_end) begin
        st_r            <= ST_CMD;
        cnt_r           <= 5'h00;
        spi_miso_oe_n_o <= 1'b1;
        if (!busy_r) begin
          if (cmd_r == `FSW_CMD_WREN && st_r == ST_IGN)
            sr_r[`FSW_WEL_BIT] <= 1'b1;
          if (cmd_r == `FSW_CMD_WRDI && st_r == ST_IGN)
            sr_r[`FSW_WEL_BIT] <= 1'b0;
          if (wel && cmd_r == `FSW_CMD_WRSR && got_data_r) begin
            if (!hw_lock) begin
              sr_r <= (wdat_r & `FSW_NV_MASK) | (sr_r & ~`FSW_NV_MASK);
              busy_r <= 1'b1;
              bcnt_r <= BUSY_CYC[15:0];
            end else begin
              sr_r[`FSW_WEL_BIT] <= 1'b0;
            end
          end
          if (wel && (cmd_r == `FSW_CMD_PP || cmd_r == `FSW_CMD_SE)
              && addr_ok_r) begin
            if (hit) begin
              prot_err_o         <= 1'b1;
              sr_r[`FSW_WEL_BIT] <= 1'b0;
            end else begin
              prot_err_o <= 1'b0;
              array_go_o <= 1'b1;
              busy_r     <= 1'b1;
              bcnt_r     <= BUSY_CYC[15:0];
            end
          end
          if (wel && cmd_r == `FSW_CMD_BE && st_r == ST_IGN) begin
            if (bp == 4'h0) begin
              prot_err_o <= 1'b0;
              array_go_o <= 1'b1;
              busy_r     <= 1'b1;
              bcnt_r     <= BUSY_CYC[15:0];
            end else begin
              prot_err_o         <= 1'b1;
              sr_r[`FSW_WEL_BIT] <= 1'b0;
            end
          end
        end
      end
      // Ready is inverse of busy bit
      ready_o  <= ~busy_r;
      status_o <= {sr_r[7:1], busy_r};
    end
  end
endmodule // fsw_status

/* File: testbench/fsw_status_sva.sv */
module fsw_status_chk #(
  parameter BUSY_CYC = 2
) (
  input wire       mclk_i,     // Clock
  input wire       sys_rst_i,  // Reset
  input wire       wp_n_i,     // Lock pin
  input wire       ready_o,    // Ready
  input wire       array_go_o, // Accepted
  input wire [7:0] status_o    // Status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lo_cnt_r;
  // Busy length counted here, too long for a repetition
  always @(posedge mclk_i) lo_cnt_r <= ready_o ? 8'h00 : lo_cnt_r + 8'h01;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  reset_clr_a: assert property (
    $fell(sys_rst_i) |-> status_o == 8'h00 && ready_o)
    else $error("Bad reset value");
  busy_flag_a: assert property (
    $stable(ready_o) && $stable(status_o[0]) |-> ready_o != status_o[0])
    else $error("Busy bit not inverse of ready");
  busy_len_a: assert property (
    $rose(ready_o) |-> lo_cnt_r == BUSY_CYC + 1)
    else $error("Wrong busy length");
  wel_clear_a: assert property (
    $rose(ready_o) |-> ##[0:2] !status_o[1])
    else $error("Latch kept after cycle");
  go_pulse_a: assert property (
    array_go_o |=> !array_go_o)
    else $error("Accept pulse too long");
  go_wel_a: assert property (
    array_go_o |-> $past(status_o[1]))
    else $error("Accepted without latch");
  go_busy_a: assert property (
    array_go_o |-> ##[0:4] !ready_o)
    else $error("No busy after accept");
  hw_lock_a: assert property (
    status_o[7] && !wp_n_i && !$past(wp_n_i, 4) |=> $stable(status_o[7:2]))
    else $error("Locked bits changed");
  cover property (array_go_o);
  cover property ($rose(ready_o));
  cover property (status_o[7] && !wp_n_i);
endmodule // fsw_status_chk

bind fsw_status fsw_status_chk #(.BUSY_CYC(BUSY_CYC)) fsw_status_chk_i (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wp_n_i(wp_n_i),
  .ready_o(ready_o), .array_go_o(array_go_o), .status_o(status_o));

/* File: testbench/fsw_host.sv */
module fsw_host (
  input  wire logic        mclk_i, // Clock
  input  wire logic        go_i,   // Start
  input  wire logic [5:0]  nbits_i,// Bit count
  input  wire logic [31:0] tx_i,   // MSB first
  input  wire logic        miso_i, // Device data
  input  wire logic        oe_n_i, // Device enable
  output logic             sclk_o, // Serial clock
  output logic             cs_n_o, // Select
  output logic             mosi_o, // Host data
  output logic             busy_o, // Frame on
  output logic [7:0]       rx_o    // Bits in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    busy_o = 1'b0;
    rx_o = 8'h00;
  end
  always @(posedge go_i) begin
    busy_o = 1'b1;
    @(negedge mclk_i) cs_n_o = 1'b0;
    for (int i = 0; i < nbits_i; i++) begin
      mosi_o = tx_i[31 - i];
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b1;
      // Released line reads as the inverse of its last bit
      rx_o = {rx_o[6:0], oe_n_i ? ~rx_o[0] : miso_i};
      repeat (4) @(negedge mclk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge mclk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(negedge mclk_i);
    busy_o = 1'b0;
  end
endmodule // fsw_host

/* File: testbench/fsw_status_tb_top.sv */
module fsw_status_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk = 1'b0, rst = 1'b1, wp_n = 1'b1, go = 1'b0;
  logic [5:0]  nbits = 6'h00;
  logic [31:0] tx = 32'h0;
  logic        sclk, cs_n, mosi, busy, miso, oe_n, ready, perr, agoes;
  logic        go_seen, wip_seen;
  logic [7:0]  rx, status;
  int          failures = 0, checks_done = 0, cycles = 0;
  // Rows: protect pin, written byte, expected status
  logic [16:0] rows [5] = '{17'h12F2C, 17'h15C5C, 17'h18080, 17'h00080,
                            17'h10000};
  // Ops after write enable: expected flags, bit count, frame
  logic [47:0] ops [13] = '{48'h80_10_0124_0000, 48'h04_20_D800_0000,
    48'h82_20_D801_0000, 48'h04_08_C700_0000, 48'h84_10_0128_0000,
    48'h04_20_0201_FFFF, 48'h82_20_0202_0000, 48'h80_10_0108_0000,
    48'h82_20_D800_0000, 48'h80_10_0148_0000, 48'h04_20_D800_0000,
    48'h84_10_0100_0000, 48'h82_08_C700_0000};
  fsw_status #(.BUSY_CYC(2)) fsw_status_i (
    .mclk_i(mclk), .sys_rst_i(rst), .spi_clk_i(sclk), .spi_cs_n_i(cs_n),
    .spi_mosi_i(mosi), .wp_n_i(wp_n), .spi_miso_o(miso),
    .spi_miso_oe_n_o(oe_n), .ready_o(ready), .prot_err_o(perr),
    .array_go_o(agoes), .status_o(status));
  fsw_host fsw_host_i (
    .mclk_i(mclk), .go_i(go), .nbits_i(nbits), .tx_i(tx), .miso_i(miso),
    .oe_n_i(oe_n), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .busy_o(busy), .rx_o(rx));
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (agoes === 1'b1) go_seen <= 1'b1;
    if (status[0] === 1'b1) wip_seen <= 1'b1;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic frame(input logic [5:0] n, input logic [31:0] d);
    int k;
    @(negedge mclk);
    nbits = n;
    tx = d;
    go = 1'b1;
    go_seen = 1'b0;
    wip_seen = 1'b0;
    @(negedge mclk);
    go = 1'b0;
    k = 0;
    while ((busy || ready !== 1'b1) && k < 2000) begin
      @(negedge mclk);
      k++;
    end
  endtask
  task automatic stop_test;
    $display("Checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    foreach (rows[r]) begin
      wp_n = rows[r][16];
      frame(6'h08, 32'h0600_0000);
      frame(6'h10, {8'h01, rows[r][15:8], 16'h0000});
      frame(6'h10, 32'h0500_0000);
      chk(rx, rows[r][7:0]);
      chk(status, rows[r][7:0]);
      $display("Row %0d done", r);
    end
    foreach (ops[o]) begin
      frame(6'h08, 32'h0600_0000);
      frame(ops[o][37:32], ops[o][31:0]);
      chk({wip_seen, 4'h0, perr, go_seen, status[1]}, ops[o][47:40]);
      $display("Op %0d done", o);
    end
    frame(6'h08, 32'h0600_0000);
    chk(status, 8'h02);
    rst = 1'b1;
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    chk({7'h00, ready}, 8'h01);
    chk(status, 8'h00);
    repeat (4) @(negedge mclk);
    frame(6'h10, 32'h011C_0000);
    chk(status, 8'h00);
    $display("Reset test done");
    stop_test();
  end
endmodule // fsw_status_tb_top
